// ===== src/jtap_tap_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtap_consts.svh"

// What this block does
// R1: Sixteen-state controller with a data branch and an instruction branch.
// R2: Each transition decided by mode-select sampled at rising test-clock edge.
// R3: Reset state disables test logic and loads the identification instruction.
// R4: Reset state entered at power-up and held while mode-select is high.
// R5: Idle stays on low, goes to data select on high, contents held.
// R6: Data select goes to data capture on low, instruction select on high.
// R7: Data capture loads pin values into chain for boundary instructions.
// R8: Data shift moves selected register one stage toward the serial output.
// R9: Exit1 data goes to update on high, pause on low.
// R10: Data pause holds register while low, moves to exit2 on high.
// R11: Exit2 data goes to update on high, back to shift on low.
// R12: Chain parallel output latches on falling edge only in data update.
// R13: Instruction select goes to capture on low, reset state on high.
// R14: Instruction capture loads fixed pattern 100.
// R15: Instruction shift moves instruction register one stage toward output.
// R16: Exit1 instruction goes to update on high, pause on low.
// R17: Instruction pause holds while low, moves to exit2 on high.
// R18: Exit2 instruction goes to update on high, back to shift on low.
// R19: Instruction update latches on falling edge and becomes current.
// R20: Chain bit 87 set tri-states channel 6 receive outputs while the current instruction is EXTEST.
// R21: Identification register is 32 bits, shifted out low bit first.
// R22: Bypass register is one bit between serial input and output.
// R23: Chain is a 98-bit register used by the boundary instructions.
// R24: Five high mode-select edges reach the reset state from anywhere.
// R25: Update states go to data select on high, idle on low.
module jtap_tap_controller #(
  parameter logic [31:0] ID_VALUE = `JTAP_ID_VALUE // Arbitrary value.
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        testClk,
  input  wire logic                        testModeSel,
  input  wire logic                        testDataIn,
  input  wire logic [`JTAP_CHAIN_LEN-1:0]  chainPinsIn,
  output logic                             testDataOut,
  output logic                             testDataOutEn,
  output logic [`JTAP_CHAIN_LEN-1:0]       chainParallelOut,
  output logic                             rxCh6OutputTristate,
  output logic                             testLogicActive,
  output logic [`JTAP_IR_WIDTH-1:0]        currentInstr,
  output jtap_pkg::jtap_state_e            tapState
);

  // ****************************************************************
  // Pin sampling and edge detection
  // ****************************************************************
  logic tckSync;
  logic tmsSync;
  logic tdiSync;
  logic tckPrevReg;
  logic tckRise;
  logic tckFall;

  jtap_sync uTck (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn (testClk),
    .syncOut (tckSync)
  );

  jtap_sync uTms (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn (testModeSel),
    .syncOut (tmsSync)
  );

  jtap_sync uTdi (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn (testDataIn),
    .syncOut (tdiSync)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tckPrevReg <= 1'b0;
    end else begin
      tckPrevReg <= tckSync;
    end
  end

  // The parallel pins come from outside the clock domain. Each bit crosses on its own;
  // capture comes many system clocks after the pins settle, so no torn word is taken.
  logic [`JTAP_CHAIN_LEN-1:0] chainPinsMetaReg;
  logic [`JTAP_CHAIN_LEN-1:0] chainPinsSyncReg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chainPinsMetaReg <= `JTAP_CHAIN_RESET;
      chainPinsSyncReg <= `JTAP_CHAIN_RESET;
    end else begin
      chainPinsMetaReg <= chainPinsIn;
      chainPinsSyncReg <= chainPinsMetaReg;
    end
  end

  // Mode-select and data travel through the same two-flop delay as the
  // test clock, so they are still the levels set up before the edge.
  assign tckRise = tckSync & ~tckPrevReg;
  assign tckFall = ~tckSync & tckPrevReg;

  // ****************************************************************
  // State machine
  // ****************************************************************
  jtap_pkg::jtap_state_e stateReg;
  jtap_pkg::jtap_state_e stateNext;

  // R1: sixteen states
  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      // R4: held high
      jtap_pkg::TEST_LOGIC_RESET: begin
        // R4: leave on low
        stateNext = tmsSync ? jtap_pkg::TEST_LOGIC_RESET : jtap_pkg::RUN_TEST_IDLE;
      end
      // R5: idle
      jtap_pkg::RUN_TEST_IDLE: begin
        stateNext = tmsSync ? jtap_pkg::SELECT_DR : jtap_pkg::RUN_TEST_IDLE;
      end
      // R6: data select
      jtap_pkg::SELECT_DR: begin
        stateNext = tmsSync ? jtap_pkg::SELECT_IR : jtap_pkg::CAPTURE_DR;
      end
      // R7: data capture
      jtap_pkg::CAPTURE_DR: begin
        stateNext = tmsSync ? jtap_pkg::EXIT1_DR : jtap_pkg::SHIFT_DR;
      end
      // R8: data shift
      jtap_pkg::SHIFT_DR: begin
        stateNext = tmsSync ? jtap_pkg::EXIT1_DR : jtap_pkg::SHIFT_DR;
      end
      // R9: exit1 data
      jtap_pkg::EXIT1_DR: begin
        stateNext = tmsSync ? jtap_pkg::UPDATE_DR : jtap_pkg::PAUSE_DR;
      end
      // R10: data pause
      jtap_pkg::PAUSE_DR: begin
        stateNext = tmsSync ? jtap_pkg::EXIT2_DR : jtap_pkg::PAUSE_DR;
      end
      // R11: exit2 data
      jtap_pkg::EXIT2_DR: begin
        stateNext = tmsSync ? jtap_pkg::UPDATE_DR : jtap_pkg::SHIFT_DR;
      end
      // R13: instruction select
      jtap_pkg::SELECT_IR: begin
        stateNext = tmsSync ? jtap_pkg::TEST_LOGIC_RESET : jtap_pkg::CAPTURE_IR;
      end
      // R14: instruction capture
      jtap_pkg::CAPTURE_IR: begin
        stateNext = tmsSync ? jtap_pkg::EXIT1_IR : jtap_pkg::SHIFT_IR;
      end
      // R15: instruction shift
      jtap_pkg::SHIFT_IR: begin
        stateNext = tmsSync ? jtap_pkg::EXIT1_IR : jtap_pkg::SHIFT_IR;
      end
      // R16: exit1 instruction
      jtap_pkg::EXIT1_IR: begin
        stateNext = tmsSync ? jtap_pkg::UPDATE_IR : jtap_pkg::PAUSE_IR;
      end
      // R17: instruction pause
      jtap_pkg::PAUSE_IR: begin
        stateNext = tmsSync ? jtap_pkg::EXIT2_IR : jtap_pkg::PAUSE_IR;
      end
      // R18: exit2 instruction
      jtap_pkg::EXIT2_IR: begin
        stateNext = tmsSync ? jtap_pkg::UPDATE_IR : jtap_pkg::SHIFT_IR;
      end
      // R25: leave update
      jtap_pkg::UPDATE_DR,
      jtap_pkg::UPDATE_IR: begin
        stateNext = tmsSync ? jtap_pkg::SELECT_DR : jtap_pkg::RUN_TEST_IDLE;
      end
    endcase
  end

  // R2: step on rising edge
  // R24: five-high reset path follows from the transitions
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stateReg <= jtap_pkg::TEST_LOGIC_RESET;
    end else if (tckRise) begin
      stateReg <= stateNext;
    end
  end

  // ****************************************************************
  // Instruction register
  // ****************************************************************
  logic [`JTAP_IR_WIDTH-1:0] irShiftReg;
  logic [`JTAP_IR_WIDTH-1:0] irCurrentReg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irShiftReg <= `JTAP_IR_CAPTURE;
    end else if (tckRise) begin
      // R14: fixed capture
      if (stateReg == jtap_pkg::CAPTURE_IR) begin
        irShiftReg <= `JTAP_IR_CAPTURE;
      // R15: shift toward output
      end else if (stateReg == jtap_pkg::SHIFT_IR) begin
        irShiftReg <= {tdiSync, irShiftReg[`JTAP_IR_WIDTH-1:1]};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irCurrentReg <= `JTAP_INS_IDCODE;
    // R3: reset loads identification
    end else if (stateReg == jtap_pkg::TEST_LOGIC_RESET) begin
      irCurrentReg <= `JTAP_INS_IDCODE;
    // R19: falling-edge latch
    end else if (tckFall && stateReg == jtap_pkg::UPDATE_IR) begin
      irCurrentReg <= irShiftReg;
    end
  end

  // ****************************************************************
  // Data registers
  // ****************************************************************
  logic                        selChain;
  logic                        selId;
  logic [`JTAP_ID_WIDTH-1:0]   idShiftReg;
  logic                        bypassReg;
  logic [`JTAP_CHAIN_LEN-1:0]  chainShiftReg;
  logic [`JTAP_CHAIN_LEN-1:0]  chainLatchReg;

  // R23: boundary instructions select the chain
  assign selChain = (irCurrentReg == `JTAP_INS_EXTEST) || (irCurrentReg == `JTAP_INS_SAMPLE);
  assign selId    = (irCurrentReg == `JTAP_INS_IDCODE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idShiftReg <= `JTAP_ID_WIDTH'(0);
    end else if (tckRise && selId) begin
      if (stateReg == jtap_pkg::CAPTURE_DR) begin
        idShiftReg <= ID_VALUE;
      // R21: low bit first
      end else if (stateReg == jtap_pkg::SHIFT_DR) begin
        idShiftReg <= {tdiSync, idShiftReg[`JTAP_ID_WIDTH-1:1]};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bypassReg <= 1'b0;
    end else if (tckRise && !selChain && !selId) begin
      if (stateReg == jtap_pkg::CAPTURE_DR) begin
        bypassReg <= 1'b0;
      // R22: one-bit path
      end else if (stateReg == jtap_pkg::SHIFT_DR) begin
        bypassReg <= tdiSync;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chainShiftReg <= `JTAP_CHAIN_RESET;
    end else if (tckRise && selChain) begin
      // R7: capture pins
      if (stateReg == jtap_pkg::CAPTURE_DR) begin
        chainShiftReg <= chainPinsSyncReg;
      // R8: shift chain
      end else if (stateReg == jtap_pkg::SHIFT_DR) begin
        chainShiftReg <= {tdiSync, chainShiftReg[`JTAP_CHAIN_LEN-1:1]};
      end
    end
  end

  // R12: latch only in update
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chainLatchReg <= `JTAP_CHAIN_RESET;
    end else if (tckFall && selChain && stateReg == jtap_pkg::UPDATE_DR) begin
      chainLatchReg <= chainShiftReg;
    end
  end

  // ****************************************************************
  // Serial output, changing on the falling edge
  // ****************************************************************
  logic tdoBit;

  always_comb begin
    tdoBit = bypassReg;
    if (stateReg == jtap_pkg::SHIFT_IR) begin
      tdoBit = irShiftReg[0];
    end else if (selChain) begin
      tdoBit = chainShiftReg[0];
    end else if (selId) begin
      tdoBit = idShiftReg[0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      testDataOut   <= 1'b0;
      testDataOutEn <= 1'b0;
    end else if (tckFall) begin
      testDataOut   <= tdoBit;
      testDataOutEn <= (stateReg == jtap_pkg::SHIFT_DR) || (stateReg == jtap_pkg::SHIFT_IR);
    end
  end

  assign chainParallelOut = chainLatchReg;

  // Registered so the pin-facing controls never glitch while the decode settles.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxCh6OutputTristate <= 1'b0;
      testLogicActive     <= 1'b0;
    end else begin
      // R20: bit 87 tri-states channel 6 under EXTEST
      rxCh6OutputTristate <= chainLatchReg[`JTAP_RX6_HZ_BIT] & (irCurrentReg == `JTAP_INS_EXTEST);
      // R3: normal operation in reset state
      testLogicActive     <= (irCurrentReg == `JTAP_INS_EXTEST);
    end
  end

  assign currentInstr    = irCurrentReg;
  assign tapState        = stateReg;

endmodule : jtap_tap_controller

`default_nettype wire

// ===== include/jtap_consts.svh
`ifndef JTAP_CONSTS_SVH
`define JTAP_CONSTS_SVH

`define JTAP_IR_WIDTH        3
`define JTAP_IR_CAPTURE      3'h4
`define JTAP_INS_EXTEST      3'h0
`define JTAP_INS_SAMPLE      3'h1
`define JTAP_INS_IDCODE      3'h2
`define JTAP_INS_BYPASS      3'h7
`define JTAP_ID_WIDTH        32
`define JTAP_ID_VALUE        32'h0000_0001
`define JTAP_CHAIN_LEN       98
`define JTAP_RX6_HZ_BIT      87
`define JTAP_CHAIN_RESET     98'h0
`define JTAP_RESET_TMS_EDGES 5

`endif

// ===== include/jtap_pkg.sv
package jtap_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } jtap_state_e;

endpackage : jtap_pkg

// ===== src/jtap_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser; the first stage feeds only the second.
module jtap_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1Reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1Reg <= 1'b0;
      syncOut   <= 1'b0;
    end else begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end

endmodule : jtap_sync

`default_nettype wire

// ===== verif/jtap_tester.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Board tester model
// ****************************************
module jtap_tester (
  input  wire logic mclk,
  input  wire logic testDataOut,
  output var logic  testClk,
  output var logic  testModeSel,
  output var logic  testDataIn
);
  initial begin
    testClk     = 1'b0;
    testModeSel = 1'b1;
    testDataIn  = 1'b0;
  end

  // The test clock rests low between calls; its falling-edge effects land about three system clocks after a step returns.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(negedge mclk);
    testModeSel = tms;
    testDataIn  = tdi;
    repeat (8) @(negedge mclk);
    tdo     = testDataOut;
    testClk = 1'b1;
    repeat (8) @(negedge mclk);
    testClk    = 1'b0;
    testDataIn = ~tdi;
  endtask : step

  task automatic reset_walk();
    logic d;
    repeat (5) step(1'b1, 1'b0, d);
  endtask : reset_walk
endmodule : jtap_tester
`default_nettype wire

// ===== verif/jtap_tap_controller_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtap_consts.svh"
// ****************************************
// Port checker
// ****************************************
module jtap_tap_controller_sva (
  input wire logic                       mclk,
  input wire logic                       rst,
  input wire logic                       testClk,
  input wire logic                       testModeSel,
  input wire logic                       testDataIn,
  input wire logic [`JTAP_CHAIN_LEN-1:0] chainPinsIn,
  input wire logic                       testDataOut,
  input wire logic                       testDataOutEn,
  input wire logic [`JTAP_CHAIN_LEN-1:0] chainParallelOut,
  input wire logic                       rxCh6OutputTristate,
  input wire logic                       testLogicActive,
  input wire logic [`JTAP_IR_WIDTH-1:0]  currentInstr,
  input wire jtap_pkg::jtap_state_e      tapState
);
  // Successor of state i sits in nibble i, one table per mode-select level.
  localparam logic [63:0] NEXT_HI = 64'h2FEF_CC02_8785_5920;
  localparam logic [63:0] NEXT_LO = 64'h1BDD_BBA1_4664_4311;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_tlr_held;
    (tapState == jtap_pkg::TEST_LOGIC_RESET) [*3];
  endsequence
  property p_next;
    $changed(tapState) |-> 4'(tapState) == (testModeSel ? NEXT_HI[{$past(tapState), 2'h0} +: 4]
                                                          : NEXT_LO[{$past(tapState), 2'h0} +: 4]);
  endproperty
  property p_rise;
    $changed(tapState) |-> testClk;
  endproperty
  property p_tlr;
    s_tlr_held |-> currentInstr == `JTAP_INS_IDCODE && !testLogicActive;
  endproperty
  property p_reset;
    $fell(rst) |-> tapState == jtap_pkg::TEST_LOGIC_RESET && currentInstr == `JTAP_INS_IDCODE;
  endproperty
  property p_instr;
    $changed(currentInstr) |-> tapState == jtap_pkg::TEST_LOGIC_RESET ||
      $past(tapState) inside {jtap_pkg::UPDATE_IR, jtap_pkg::TEST_LOGIC_RESET};
  endproperty
  property p_chain;
    $changed(chainParallelOut) |-> $past(tapState) == jtap_pkg::UPDATE_DR &&
      $past(currentInstr) inside {`JTAP_INS_EXTEST, `JTAP_INS_SAMPLE};
  endproperty
  property p_rx6;
    $stable(currentInstr) && $stable(chainParallelOut) |-> rxCh6OutputTristate ==
      (currentInstr == `JTAP_INS_EXTEST && chainParallelOut[`JTAP_RX6_HZ_BIT]);
  endproperty
  property p_active;
    $stable(currentInstr) |-> testLogicActive == (currentInstr == `JTAP_INS_EXTEST);
  endproperty
  property p_tdo;
    $changed(testDataOut) |-> !testClk;
  endproperty
  property p_oe;
    testDataOutEn |-> tapState inside {jtap_pkg::SHIFT_DR, jtap_pkg::EXIT1_DR,
                                       jtap_pkg::SHIFT_IR, jtap_pkg::EXIT1_IR};
  endproperty
  a_next : assert property (p_next) else $error("bad state step");
  a_rise : assert property (p_rise) else $error("state moved off rise");
  a_tlr : assert property (p_tlr) else $error("reset state instr");
  a_reset : assert property (p_reset) else $error("power-up state");
  a_instr : assert property (p_instr) else $error("instr changed");
  a_chain : assert property (p_chain) else $error("latch changed");
  a_rx6 : assert property (p_rx6) else $error("rx6 tristate");
  a_active : assert property (p_active) else $error("test logic active");
  a_tdo : assert property (p_tdo) else $error("tdo moved on high");
  a_oe : assert property (p_oe) else $error("tdo enable");
endmodule : jtap_tap_controller_sva

bind jtap_tap_controller jtap_tap_controller_sva i_jtap_tap_controller_sva (
  .mclk(mclk), .rst(rst), .testClk(testClk), .testModeSel(testModeSel),
  .testDataIn(testDataIn), .chainPinsIn(chainPinsIn), .testDataOut(testDataOut),
  .testDataOutEn(testDataOutEn), .chainParallelOut(chainParallelOut),
  .rxCh6OutputTristate(rxCh6OutputTristate), .testLogicActive(testLogicActive),
  .currentInstr(currentInstr), .tapState(tapState)
);
`default_nettype wire

// ===== verif/jtag_tap_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtap_consts.svh"
// ****************************************
// Testbench
// ****************************************
module jtag_tap_controller_tb;
  localparam int          N  = `JTAP_CHAIN_LEN;
  localparam logic [31:0] ID = 32'h5A3C_0F01; // Arbitrary value.
  logic                  mclk, rst, testClk, testModeSel, testDataIn;
  logic                  testDataOut, testDataOutEn, rxCh6OutputTristate, testLogicActive;
  logic [N-1:0]          chainPinsIn, chainParallelOut, latch, pat, got;
  logic [2:0]            currentInstr, ins;
  jtap_pkg::jtap_state_e tapState;
  int                    num_errors = 0;
  int                    n_compared = 0;

  jtap_tap_controller #(.ID_VALUE(ID)) i_jtap_tap_controller (
    .mclk(mclk), .rst(rst), .testClk(testClk), .testModeSel(testModeSel),
    .testDataIn(testDataIn), .chainPinsIn(chainPinsIn), .testDataOut(testDataOut),
    .testDataOutEn(testDataOutEn), .chainParallelOut(chainParallelOut),
    .rxCh6OutputTristate(rxCh6OutputTristate), .testLogicActive(testLogicActive),
    .currentInstr(currentInstr), .tapState(tapState));
  jtap_tester i_jtap_tester (.mclk(mclk), .testDataOut(testDataOut), .testClk(testClk),
    .testModeSel(testModeSel), .testDataIn(testDataIn));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic test_done();
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [N-1:0] g, input logic [N-1:0] e, input string what);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, g, e);
    end
  endtask : chk

  function automatic logic [N-1:0] rnd();
    return N'({$urandom, $urandom, $urandom, $urandom});
  endfunction : rnd

  function automatic logic rx6(input logic [2:0] i, input logic [N-1:0] l);
    return i == `JTAP_INS_EXTEST && l[`JTAP_RX6_HZ_BIT];
  endfunction : rx6

  // Mode-select levels are applied lowest bit first.
  task automatic seq(input logic [7:0] bits, input int n);
    logic d;
    for (int i = 0; i < n; i++)
      i_jtap_tester.step(bits[i], 1'($urandom), d);
  endtask : seq

  // A scan from a shift state, parked in pause halfway, ending in idle.
  task automatic scan(input int n, input logic [N-1:0] din, output logic [N-1:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(negedge mclk);
      chk(N'(testDataOutEn), N'(1'b1), "tdo enable");
      i_jtap_tester.step(i == n / 2 - 1 || i == n - 1, din[i], dout[i]);
      if (i == n / 2 - 1)
        seq(8'h04, 4);
    end
    seq(8'h01, 2);
    repeat (4) @(negedge mclk);
    chk(N'(testDataOutEn), N'(1'b0), "tdo idle");
  endtask : scan

  task automatic loadIr(input logic [2:0] i);
    seq(8'h03, 4);
    scan(3, N'(i), got);
    chk(got, N'(`JTAP_IR_CAPTURE), "ir capture");
    chk(N'(currentInstr), N'(i), "ir update");
  endtask : loadIr

  task automatic drScan(input int n, input logic [N-1:0] din);
    seq(8'h01, 3);
    scan(n, din, got);
  endtask : drScan

  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    test_done();
  end

  initial begin
    rst         = 1'b1;
    chainPinsIn = '0;
    latch       = '0;
    void'($urandom(35));
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk(N'(tapState), N'(jtap_pkg::TEST_LOGIC_RESET), "reset state");
    chk(N'(currentInstr), N'(`JTAP_INS_IDCODE), "reset instr");
    seq(8'h00, 1);
    drScan(32, rnd());
    chk(N'(got[31:0]), N'(ID), "id shift");
    for (int c = 3; c < 8; c++) begin
      loadIr(3'(c));
      pat = rnd();
      drScan(8, pat);
      chk(N'(got[7:1]), N'(pat[6:0]), "bypass");
      chk(chainParallelOut, latch, "latch held");
    end
    for (int j = 0; j < 4; j++) begin
      ins = j < 2 ? `JTAP_INS_SAMPLE : `JTAP_INS_EXTEST;
      loadIr(ins);
      chainPinsIn = rnd();
      pat         = rnd();
      pat[`JTAP_RX6_HZ_BIT] = j[0];
      drScan(N, pat);
      latch = pat;
      chk(got, chainPinsIn, "chain capture");
      chk(chainParallelOut, latch, "chain update");
      chk(N'(rxCh6OutputTristate), N'(rx6(ins, latch)), "rx6");
      chk(N'(testLogicActive), N'(ins == `JTAP_INS_EXTEST), "active");
    end
    for (int k = 0; k < 3; k++) begin
      seq(8'($urandom), 1 + $urandom % 8);
      i_jtap_tester.reset_walk();
      repeat (4) @(negedge mclk);
      chk(N'(tapState), N'(jtap_pkg::TEST_LOGIC_RESET), "five-high reset");
      chk(N'(currentInstr), N'(`JTAP_INS_IDCODE), "reset instr");
    end
    test_done();
  end
endmodule : jtag_tap_controller_tb
`default_nettype wire
